// [rtc_pkg.sv]
// Purpose: Shared constants for the seconds clock with trim and alarm.
// Assumes: One 40 MHz core clock; the crystal arrives as a sampled level.
// Notes: Register indices, field positions, reset values and timings.
package rtc_pkg;

  // ----------------------------------------------------------------
  // Clock rates and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned XTAL_HZ = 32_768;
  localparam int unsigned TICK_HZ = 1;
  localparam int unsigned LV_TIME_MS = 200;
  localparam int unsigned LV_CYCLES_DEF = CLK_HZ / 1000 * LV_TIME_MS;
  localparam int unsigned PRESCALE_W = 15;
  localparam logic [PRESCALE_W-1:0] PRESCALE_MAX =
    PRESCALE_W'(XTAL_HZ / TICK_HZ - 1);

  // ----------------------------------------------------------------
  // Posted write targets
  // ----------------------------------------------------------------
  localparam int unsigned SLOT_N = 6;
  localparam logic [2:0] IDX_CTRL = 3'h0;
  localparam logic [2:0] IDX_CNT_LO = 3'h1;
  localparam logic [2:0] IDX_CNT_HI = 3'h2;
  localparam logic [2:0] IDX_ALM_LO = 3'h3;
  localparam logic [2:0] IDX_ALM_HI = 3'h4;
  localparam logic [2:0] IDX_TRIM = 3'h5;
  localparam logic [2:0] IDX_GATEWAY = 3'h6;
  localparam logic [15:0] CANCEL_KEY = 16'hA2C5;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_CNT_EN = 0;
  localparam int unsigned CTRL_ALM_EN = 1;
  localparam int unsigned CTRL_MIN_EN = 2;
  localparam int unsigned CTRL_ROUTE_EN = 3;
  localparam int unsigned CTRL_OFS_LSB = 4;
  localparam int unsigned CTRL_OFS_MSB = 9;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Trim fields and resets of the time registers
  // ----------------------------------------------------------------
  localparam int unsigned TRIM_MAG_MSB = 2;
  localparam int unsigned TRIM_NEG = 3;
  localparam int unsigned TRIM_SEL_LSB = 4;
  localparam int unsigned TRIM_SEL_MSB = 5;
  localparam int unsigned TRIM_BASE_EXP = 14;
  localparam int unsigned TRIM_CNT_W = 18;
  localparam logic [15:0] TRIM_RESET = 16'h0000;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [31:0] ALARM_RESET = 32'hFFFF_FFFF;
  localparam logic [5:0] MIN_LAST = 6'h3B;

endpackage

// [seconds_rtc.sv]
// Purpose: Seconds counter clock with prescaler, trim, alarm and fail flag.
// Assumes: Crystal level and write strobes are synchronous to ref_clk.
// Notes: The slow domain steps once on each rising crystal edge.
`timescale 1ns/10ps

module seconds_rtc
  import rtc_pkg::*;
#(
  parameter int unsigned LV_CYCLES = LV_CYCLES_DEF
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic lv_trip,
  input wire logic xtal_in,
  input wire logic wr_stb,
  input wire logic [2:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic clr_alarm,
  input wire logic clr_fail,
  input wire logic clr_minute,
  input wire logic clr_slot_free,
  output logic [31:0] count_out,
  output logic [31:0] alarm_out,
  output logic [15:0] ctrl_out,
  output logic [15:0] trim_out,
  output logic [SLOT_N-1:0] pending_out,
  output logic slot_free_flag,
  output logic alarm_flag,
  output logic fail_flag,
  output logic minute_flag,
  output logic alarm_irq,
  output logic fail_irq,
  output logic minute_irq,
  output logic wake,
  output logic xtal_gpio
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  localparam int unsigned LV_W = 24;
  if (LV_CYCLES < 1 || LV_CYCLES >= (1 << LV_W)) begin : g_lv_check
    $error("LV_CYCLES out of range");
  end

  // ----------------------------------------------------------------
  // Reset release and supply dip filter
  // ----------------------------------------------------------------
  logic rst_q1_r;
  logic rst_q2_r;
  logic [LV_W-1:0] lv_cnt_r;
  logic lv_rst_r;

  // Releases the asynchronous reset through two flip-flops.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_q1_r <= 1'b0;
      rst_q2_r <= 1'b0;
    end else begin
      rst_q1_r <= 1'b1;
      rst_q2_r <= rst_q1_r;
    end
  end

  // Times the low supply; a dip held long enough pulses a block reset.
  always_ff @(posedge ref_clk or negedge rst_q2_r) begin
    if (!rst_q2_r) begin
      lv_cnt_r <= '0;
      lv_rst_r <= 1'b0;
    end else begin
      lv_rst_r <= 1'b0;
      if (!lv_trip) begin
        lv_cnt_r <= '0;
      end else if (lv_cnt_r == LV_W'(LV_CYCLES - 1)) begin
        lv_rst_r <= 1'b1;
        lv_cnt_r <= lv_cnt_r + LV_W'(1);
      end else if (lv_cnt_r < LV_W'(LV_CYCLES)) begin
        lv_cnt_r <= lv_cnt_r + LV_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Crystal sampling and pin routing
  // ----------------------------------------------------------------
  logic xtal_r;
  logic xtal_d_r;
  logic xtal_gpio_r;
  logic xtal_step;
  logic [15:0] ctrl_r;

  assign xtal_step = xtal_r & ~xtal_d_r;

  // Samples the crystal and drives the measurement pin when routed.
  always_ff @(posedge ref_clk or negedge rst_q2_r) begin
    if (!rst_q2_r) begin
      xtal_r <= 1'b0;
      xtal_d_r <= 1'b0;
      xtal_gpio_r <= 1'b0;
    end else begin
      xtal_r <= xtal_in;
      xtal_d_r <= xtal_r;
      xtal_gpio_r <= ctrl_r[CTRL_ROUTE_EN] & xtal_r;
    end
  end

  // ----------------------------------------------------------------
  // Posted write slots
  // ----------------------------------------------------------------
  logic [SLOT_N-1:0] pending_r;
  logic [15:0] slot_data_r [SLOT_N];
  logic [SLOT_N-1:0] disp;
  logic cancel;
  logic slot_free_r;

  assign disp = xtal_step ? pending_r : '0;
  assign cancel = wr_stb && wr_idx == IDX_GATEWAY && wr_data == CANCEL_KEY;

  // Takes a write into its slot only while that slot is empty.
  always_ff @(posedge ref_clk or negedge rst_q2_r) begin
    if (!rst_q2_r) begin
      pending_r <= '0;
      for (int i = 0; i < SLOT_N; i++) begin
        slot_data_r[i] <= 16'h0000;
      end
    end else if (lv_rst_r || cancel) begin
      pending_r <= '0;
    end else begin
      pending_r <= pending_r & ~disp;
      if (wr_stb && wr_idx < 3'(SLOT_N) && !pending_r[wr_idx]) begin
        pending_r[wr_idx] <= 1'b1;
        slot_data_r[wr_idx] <= wr_data;
      end
    end
  end

  // Sticky event when a slot frees; a new event beats a clear.
  always_ff @(posedge ref_clk or negedge rst_q2_r) begin
    if (!rst_q2_r) begin
      slot_free_r <= 1'b0;
    end else if (lv_rst_r) begin
      slot_free_r <= 1'b0;
    end else if (|disp) begin
      slot_free_r <= 1'b1;
    end else if (clr_slot_free) begin
      slot_free_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control, alarm and trim registers
  // ----------------------------------------------------------------
  logic [31:0] alarm_r;
  logic [15:0] trim_r;
  logic reenable;

  assign reenable = disp[IDX_CTRL] && slot_data_r[IDX_CTRL][CTRL_CNT_EN]
    && !ctrl_r[CTRL_CNT_EN];

  // Applies dispatched control, alarm and trim values.
  always_ff @(posedge ref_clk or negedge rst_q2_r) begin
    if (!rst_q2_r) begin
      ctrl_r <= CTRL_RESET;
      alarm_r <= ALARM_RESET;
      trim_r <= TRIM_RESET;
    end else if (lv_rst_r) begin
      ctrl_r <= CTRL_RESET;
      alarm_r <= ALARM_RESET;
      trim_r <= TRIM_RESET;
    end else begin
      if (disp[IDX_CTRL]) begin
        ctrl_r <= slot_data_r[IDX_CTRL];
      end
      if (disp[IDX_ALM_LO]) begin
        alarm_r[15:0] <= slot_data_r[IDX_ALM_LO];
      end
      if (disp[IDX_ALM_HI]) begin
        alarm_r[31:16] <= slot_data_r[IDX_ALM_HI];
      end
      if (disp[IDX_TRIM]) begin
        trim_r <= slot_data_r[IDX_TRIM];
      end
    end
  end

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  logic [PRESCALE_W-1:0] prescale_r;
  logic load;
  logic sec_tick;

  assign load = disp[IDX_CNT_LO] | disp[IDX_CNT_HI];
  assign sec_tick = xtal_step && ctrl_r[CTRL_CNT_EN] && !load
    && prescale_r == PRESCALE_MAX;

  // Divides the crystal steps down to one tick per second.
  always_ff @(posedge ref_clk or negedge rst_q2_r) begin
    if (!rst_q2_r) begin
      prescale_r <= '0;
    end else if (lv_rst_r || load || reenable) begin
      prescale_r <= '0;
    end else if (xtal_step && ctrl_r[CTRL_CNT_EN]) begin
      if (prescale_r == PRESCALE_MAX) begin
        prescale_r <= '0;
      end else begin
        prescale_r <= prescale_r + PRESCALE_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Seconds count and trim
  // ----------------------------------------------------------------
  logic [31:0] count_r;
  logic [TRIM_CNT_W-1:0] trim_cnt_r;
  logic [TRIM_CNT_W-1:0] trim_last;
  logic trim_due;
  logic [4:0] step;
  logic [31:0] count_nxt;

  assign trim_last = TRIM_CNT_W'((1 << (TRIM_BASE_EXP
    + trim_r[TRIM_SEL_MSB:TRIM_SEL_LSB])) - 1);
  assign trim_due = trim_cnt_r == trim_last;

  // Chooses the normal step or the trimmed step for this second.
  always_comb begin
    step = 5'h01;
    if (trim_due) begin
      if (trim_r[TRIM_NEG]) begin
        step = 5'h01 - {2'h0, trim_r[TRIM_MAG_MSB:0]};
      end else begin
        step = 5'h01 + {2'h0, trim_r[TRIM_MAG_MSB:0]};
      end
    end
    count_nxt = count_r + {{27{step[4]}}, step};
  end

  // Loads the count in halves or advances it once per second.
  always_ff @(posedge ref_clk or negedge rst_q2_r) begin
    if (!rst_q2_r) begin
      count_r <= COUNT_RESET;
    end else if (lv_rst_r) begin
      count_r <= COUNT_RESET;
    end else if (load) begin
      if (disp[IDX_CNT_LO]) begin
        count_r[15:0] <= slot_data_r[IDX_CNT_LO];
      end
      if (disp[IDX_CNT_HI]) begin
        count_r[31:16] <= slot_data_r[IDX_CNT_HI];
      end
    end else if (sec_tick) begin
      count_r <= count_nxt;
    end
  end

  // Counts seconds toward the trim interval and restarts on expiry.
  always_ff @(posedge ref_clk or negedge rst_q2_r) begin
    if (!rst_q2_r) begin
      trim_cnt_r <= '0;
    end else if (lv_rst_r || disp[IDX_TRIM]) begin
      trim_cnt_r <= '0;
    end else if (sec_tick) begin
      if (trim_due) begin
        trim_cnt_r <= '0;
      end else begin
        trim_cnt_r <= trim_cnt_r + TRIM_CNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Minute position
  // ----------------------------------------------------------------
  logic [5:0] sec_in_min_r;
  logic minute_hit;

  assign minute_hit = sec_tick && ctrl_r[CTRL_MIN_EN]
    && sec_in_min_r == ctrl_r[CTRL_OFS_MSB:CTRL_OFS_LSB];

  // Tracks the second within the minute; a load marks a boundary.
  always_ff @(posedge ref_clk or negedge rst_q2_r) begin
    if (!rst_q2_r) begin
      sec_in_min_r <= '0;
    end else if (lv_rst_r || load) begin
      sec_in_min_r <= '0;
    end else if (sec_tick) begin
      if (sec_in_min_r == MIN_LAST) begin
        sec_in_min_r <= '0;
      end else begin
        sec_in_min_r <= sec_in_min_r + 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sticky flags; a new event beats a clear in the same cycle
  // ----------------------------------------------------------------
  logic alarm_flag_r;
  logic fail_flag_r;
  logic minute_flag_r;

  // Alarm flag; only a counted second can match, never a load.
  always_ff @(posedge ref_clk or negedge rst_q2_r) begin
    if (!rst_q2_r) begin
      alarm_flag_r <= 1'b0;
    end else if (lv_rst_r) begin
      alarm_flag_r <= 1'b0;
    end else if (sec_tick && ctrl_r[CTRL_ALM_EN] && count_nxt == alarm_r) begin
      alarm_flag_r <= 1'b1;
    end else if (clr_alarm) begin
      alarm_flag_r <= 1'b0;
    end
  end

  // Fail flag comes up from power-on reset and on every long dip.
  always_ff @(posedge ref_clk or negedge rst_q2_r) begin
    if (!rst_q2_r) begin
      fail_flag_r <= 1'b1;
    end else if (lv_rst_r) begin
      fail_flag_r <= 1'b1;
    end else if (clr_fail) begin
      fail_flag_r <= 1'b0;
    end
  end

  // Minute flag for the display refresh.
  always_ff @(posedge ref_clk or negedge rst_q2_r) begin
    if (!rst_q2_r) begin
      minute_flag_r <= 1'b0;
    end else if (lv_rst_r) begin
      minute_flag_r <= 1'b0;
    end else if (minute_hit) begin
      minute_flag_r <= 1'b1;
    end else if (clr_minute) begin
      minute_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt and wake outputs
  // ----------------------------------------------------------------
  logic alarm_irq_r;
  logic fail_irq_r;
  logic minute_irq_r;
  logic wake_r;

  // Registers the interrupt lines one cycle behind their flags.
  always_ff @(posedge ref_clk or negedge rst_q2_r) begin
    if (!rst_q2_r) begin
      alarm_irq_r <= 1'b0;
      fail_irq_r <= 1'b0;
      minute_irq_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      alarm_irq_r <= alarm_flag_r;
      fail_irq_r <= fail_flag_r;
      minute_irq_r <= minute_flag_r;
      wake_r <= alarm_flag_r | fail_flag_r;
    end
  end

  // Status views are the registers themselves.
  assign count_out = count_r;
  assign alarm_out = alarm_r;
  assign ctrl_out = ctrl_r;
  assign trim_out = trim_r;
  assign pending_out = pending_r;
  assign slot_free_flag = slot_free_r;
  assign alarm_flag = alarm_flag_r;
  assign fail_flag = fail_flag_r;
  assign minute_flag = minute_flag_r;
  assign alarm_irq = alarm_irq_r;
  assign fail_irq = fail_irq_r;
  assign minute_irq = minute_irq_r;
  assign wake = wake_r;
  assign xtal_gpio = xtal_gpio_r;

endmodule

// [seconds_rtc_assertions.sv]
// Purpose: Port-level checker for the seconds clock block.
// Assumes: One ref_clk domain; lv_trip high may reset the block.
// Notes: Attached by bind at the foot of this file.
`timescale 1ns/10ps

module seconds_rtc_chk
  import rtc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic lv_trip,
  input wire logic wr_stb,
  input wire logic [2:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic [31:0] count_out,
  input wire logic [31:0] alarm_out,
  input wire logic [15:0] ctrl_out,
  input wire logic [15:0] trim_out,
  input wire logic [SLOT_N-1:0] pending_out,
  input wire logic alarm_flag,
  input wire logic fail_flag,
  input wire logic alarm_irq,
  input wire logic wake,
  input wire logic xtal_gpio
);
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  // A supply dip may legally reset every register and flag output, so it masks checks.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn || lv_trip);

  chk_alarm_irq_on: assert property (
    alarm_flag [*3] |-> alarm_irq) else $error("alarm irq missing");
  chk_alarm_irq_off: assert property (
    !alarm_flag [*3] |-> !alarm_irq) else $error("alarm irq stray");
  chk_wake_on: assert property (
    (alarm_flag || fail_flag) [*5] |-> wake) else $error("no wake");
  chk_wake_off: assert property (
    (!alarm_flag && !fail_flag) [*3] |-> !wake) else $error("wake stray");
  chk_pending_set: assert property (
    wr_stb && wr_idx < 3'h6 && !pending_out[wr_idx]
    |=> pending_out[$past(wr_idx)]) else $error("slot not pending");
  chk_cancel_all: assert property (
    wr_stb && wr_idx == IDX_GATEWAY && wr_data == CANCEL_KEY
    |=> pending_out == 6'h00) else $error("cancel left pending");
  chk_count_hold: assert property (
    !ctrl_out[CTRL_CNT_EN] && !pending_out[IDX_CNT_LO]
    && !pending_out[IDX_CNT_HI] |=> $stable(count_out))
    else $error("count moved while stopped");
  // A trim second may add one plus the signed trim instead of one.
  chk_count_step: assert property (
    $changed(count_out) && $past(ctrl_out[CTRL_CNT_EN])
    && !$past(pending_out[IDX_CNT_LO]) && !$past(pending_out[IDX_CNT_HI])
    |-> count_out == $past(count_out) + 32'h1
    || count_out == $past(count_out) + 32'h1
    + ($past(trim_out[TRIM_NEG])
    ? -32'($past(trim_out[TRIM_MAG_MSB:0]))
    : 32'($past(trim_out[TRIM_MAG_MSB:0]))))
    else $error("count step not one");
  chk_alarm_match: assert property (
    $rose(alarm_flag) |-> ##[0:2]
    (count_out == alarm_out && ctrl_out[CTRL_ALM_EN]))
    else $error("alarm without match");
  chk_gpio_off: assert property (
    !ctrl_out[CTRL_ROUTE_EN] [*2] |-> !xtal_gpio)
    else $error("gpio driven while unrouted");
endmodule

bind seconds_rtc seconds_rtc_chk u_chk (
  .ref_clk(ref_clk), .rstn(rstn), .lv_trip(lv_trip), .wr_stb(wr_stb),
  .wr_idx(wr_idx), .wr_data(wr_data), .count_out(count_out),
  .alarm_out(alarm_out), .ctrl_out(ctrl_out), .trim_out(trim_out),
  .pending_out(pending_out),
  .alarm_flag(alarm_flag), .fail_flag(fail_flag), .alarm_irq(alarm_irq),
  .wake(wake), .xtal_gpio(xtal_gpio)
);

// [tb.sv]
// Purpose: Self-checking bench for the seconds clock block.
// Assumes: Crystal toggles each cycle, so one second is 65536 cycles.
// Notes: Supply trip count shortened to 20 cycles.
`timescale 1ns/10ps

module tb
  import rtc_pkg::*;
;
  logic ref_clk = 1'b0, rstn = 1'b0, lv_trip = 1'b0, xtal_in = 1'b0;
  logic wr_stb = 1'b0, clr_alarm = 1'b0, clr_fail = 1'b0;
  logic clr_minute = 1'b0, clr_slot_free = 1'b0, xtal_run = 1'b0;
  logic [2:0] wr_idx = 3'h0;
  logic [15:0] wr_data = 16'h0000;
  logic [31:0] count_out, alarm_out;
  logic [15:0] ctrl_out, trim_out;
  logic [SLOT_N-1:0] pending_out;
  logic slot_free_flag, alarm_flag, fail_flag, minute_flag;
  logic alarm_irq, fail_irq, minute_irq, wake, xtal_gpio, saw0, saw1;
  int n_errors = 0, compares = 0, cyc = 0;

  seconds_rtc #(.LV_CYCLES(20)) u_seconds_rtc (
    .ref_clk(ref_clk), .rstn(rstn), .lv_trip(lv_trip), .xtal_in(xtal_in),
    .wr_stb(wr_stb), .wr_idx(wr_idx), .wr_data(wr_data),
    .clr_alarm(clr_alarm), .clr_fail(clr_fail), .clr_minute(clr_minute),
    .clr_slot_free(clr_slot_free), .count_out(count_out),
    .alarm_out(alarm_out), .ctrl_out(ctrl_out), .trim_out(trim_out),
    .pending_out(pending_out), .slot_free_flag(slot_free_flag),
    .alarm_flag(alarm_flag), .fail_flag(fail_flag),
    .minute_flag(minute_flag), .alarm_irq(alarm_irq), .fail_irq(fail_irq),
    .minute_irq(minute_irq), .wake(wake), .xtal_gpio(xtal_gpio)
  );

  // --------------------------------------------------------------
  // Clock, crystal and hang guard
  // --------------------------------------------------------------
  // Core clock of 25 ns period.
  always #12.5 ref_clk = ~ref_clk;

  // Crystal runs only while enabled, so writes can be held pending.
  always @(negedge ref_clk) if (xtal_run) xtal_in <= ~xtal_in;

  // Cycle ceiling well above the one-second wait.
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 80000) begin
      n_errors++;
      end_sim();
    end
  end

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  // One-cycle write strobe, then an idle cycle.
  task automatic wr(input logic [2:0] i, input logic [15:0] d);
    wr_stb = 1'b1;
    wr_idx = i;
    wr_data = d;
    @(negedge ref_clk);
    wr_stb = 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s: expected %h, seen %h", s, e, g);
    end
  endtask

  // Waits, bounded, for one slot to dispatch.
  task automatic wait_free(input int i);
    for (int k = 0; k < 60 && pending_out[i] !== 1'b0; k++)
      @(negedge ref_clk);
    chk("pending slot", 32'h0, 32'(pending_out[i]));
  endtask

  task automatic end_sim();
    $display("errors %0d, compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (12) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (6) @(negedge ref_clk);
    // Reset values, with the fail flag left set and waking.
    chk("count", 32'h0, count_out);
    chk("alarm", 32'hFFFF_FFFF, alarm_out);
    chk("ctrl", 32'h0, 32'(ctrl_out));
    chk("fail_flag", 32'h1, 32'(fail_flag));
    chk("fail_irq", 32'h1, 32'(fail_irq));
    chk("wake", 32'h1, 32'(wake));
    clr_fail = 1'b1;
    @(negedge ref_clk);
    clr_fail = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk("wake after clear", 32'h0, 32'(wake));
    // Cancel key drops a held write before it lands.
    wr(IDX_ALM_LO, 16'h00AA);
    wr(IDX_GATEWAY, CANCEL_KEY);
    chk("pending after cancel", 32'h0, 32'(pending_out));
    xtal_run = 1'b1;
    repeat (10) @(negedge ref_clk);
    chk("pending before stop", 32'h0, 32'(pending_out));
    xtal_run = 1'b0;
    // A last crystal edge may still be in flight; let it settle.
    repeat (3) @(negedge ref_clk);
    chk("alarm after cancel", 32'hFFFF_FFFF, alarm_out);
    // Held slots refuse a second write; index 7 is ignored.
    wr(IDX_CNT_LO, 16'h0010);
    wr(IDX_CNT_LO, 16'h5678);
    wr(IDX_ALM_HI, 16'h0000);
    wr(IDX_ALM_LO, 16'h0010);
    wr(3'h7, 16'hFFFF);
    chk("pending held", 32'h1A, 32'(pending_out));
    xtal_run = 1'b1;
    wait_free(1);
    wait_free(3);
    wait_free(4);
    chk("count after drop", 32'h10, count_out);
    chk("alarm halves", 32'h10, alarm_out);
    chk("slot_free_flag", 32'h1, 32'(slot_free_flag));
    clr_slot_free = 1'b1;
    @(negedge ref_clk);
    clr_slot_free = 1'b0;
    @(negedge ref_clk);
    chk("slot_free cleared", 32'h0, 32'(slot_free_flag));
    // Count, alarm, minute at offset 0 and routing on a matching load.
    wr(IDX_CTRL, 16'h000F);
    wait_free(0);
    saw0 = 1'b0;
    saw1 = 1'b0;
    repeat (8) begin
      @(negedge ref_clk);
      saw0 |= !xtal_gpio;
      saw1 |= xtal_gpio;
    end
    chk("gpio both levels", 32'h1, 32'(saw0 & saw1));
    repeat (200) @(negedge ref_clk);
    chk("no alarm on load", 32'h0, 32'(alarm_flag));
    // Reload zeroes the prescaler: one second to the next step.
    wr(IDX_CNT_LO, 16'h000F);
    wait_free(1);
    repeat (65490) @(negedge ref_clk);
    chk("count before second", 32'hF, count_out);
    chk("minute early", 32'h0, 32'(minute_flag));
    repeat (90) @(negedge ref_clk);
    chk("count after second", 32'h10, count_out);
    chk("alarm_flag", 32'h1, 32'(alarm_flag));
    chk("alarm_irq", 32'h1, 32'(alarm_irq));
    chk("wake on alarm", 32'h1, 32'(wake));
    chk("minute_flag", 32'h1, 32'(minute_flag));
    chk("minute_irq", 32'h1, 32'(minute_irq));
    repeat (100) @(negedge ref_clk);
    chk("alarm held", 32'h1, 32'(alarm_flag));
    clr_alarm = 1'b1;
    clr_minute = 1'b1;
    @(negedge ref_clk);
    clr_alarm = 1'b0;
    clr_minute = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk("alarm cleared", 32'h0, 32'(alarm_irq));
    chk("minute cleared", 32'h0, 32'(minute_irq));
    // Trim: negative, magnitude 3, interval select 1.
    wr(IDX_TRIM, 16'h001B);
    wait_free(5);
    chk("trim", 32'h1B, 32'(trim_out));
    // A dip shorter than the trip time leaves the block alone.
    lv_trip = 1'b1;
    repeat (15) @(negedge ref_clk);
    lv_trip = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk("fail after short dip", 32'h0, 32'(fail_flag));
    chk("count after short dip", 32'h10, count_out);
    // Battery loss is near: cancel, then post nothing more.
    wr(IDX_GATEWAY, CANCEL_KEY);
    chk("pending at loss", 32'h0, 32'(pending_out));
    // A long dip resets the block and sets the fail flag.
    lv_trip = 1'b1;
    repeat (30) @(negedge ref_clk);
    lv_trip = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk("fail after dip", 32'h1, 32'(fail_flag));
    chk("count after dip", 32'h0, count_out);
    chk("alarm after dip", 32'hFFFF_FFFF, alarm_out);
    chk("trim after dip", 32'h0, 32'(trim_out));
    end_sim();
  end
endmodule
